// file: fps_map.svh
/*
 * Address map, function codes, exception codes and limits of the
 * fieldbus parameter slave.
 * Assumes inclusion by bare name from every file that needs it.
 */
`ifndef FPS_MAP_SVH
`define FPS_MAP_SVH

// ************************************************************
// function and exception codes
// ************************************************************
`define FPS_FC_READ 8'h03
`define FPS_FC_WRITE 8'h06
`define FPS_EXC_FLAG 8'h80
`define FPS_EXC_CMD 8'h01
`define FPS_EXC_ADDR 8'h02
`define FPS_EXC_DATA 8'h03
`define FPS_EXC_VALUE 8'h04
`define FPS_EXC_PWD 8'h05
`define FPS_EXC_FRAME 8'h06
`define FPS_EXC_RO 8'h07
`define FPS_EXC_RUN 8'h08
`define FPS_EXC_LOCK 8'h09

// ************************************************************
// addresses
// ************************************************************
`define FPS_PARAM_HI 16'h0fff
`define FPS_RUN_SRC 16'h0001
`define FPS_RUN_CHAN 16'h0002
`define FPS_PWD 16'h0700
`define FPS_LOOP_SRC 16'h0900
`define FPS_RUNLOCK_HI 16'h000f
`define FPS_PWD_CHECK 16'h1f00
`define FPS_CMD 16'h2000
`define FPS_SETPT 16'h2002
`define FPS_PULSE_A 16'h3010
`define FPS_PULSE_B 16'h3011
`define FPS_STEP 16'h3012
`define FPS_EXT_LEN 16'h3013
`define FPS_EXT_CNT 16'h3014
`define FPS_TORQUE 16'h3015
`define FPS_IDENT 16'h3016
`define FPS_FAULT 16'h5000

// ************************************************************
// value limits and reset values
// ************************************************************
`define FPS_RUN_SRC_MAX 16'h0002
`define FPS_RUN_SRC_BUS 16'h0002
`define FPS_CHAN_MAX 16'h0003
`define FPS_CHAN_BUS 16'h0000
`define FPS_LOOP_SRC_BUS 16'h0007
`define FPS_CMD_MIN 16'h0001
`define FPS_CMD_MAX 16'h0008
`define FPS_MAX_WORDS 16'h0010
`define FPS_CTRL_RST 16'h0000

`endif

// file: fps_pkg.sv
/*
 * Types shared by the fieldbus parameter slave files.
 * Assumes a framing front end that delivers decoded requests.
 */
package fps_pkg;

   // ************************************************************
   // request, answer and status carriers
   // ************************************************************
   typedef struct packed {
      logic frame_ok;    // length and crc good
      logic [7:0] func;
      logic [15:0] addr;
      logic [15:0] data; // word count on reads
   } fps_req_t;

   typedef struct packed {
      logic exc;
      logic [7:0] func;
      logic [7:0] code;  // exception code or byte count
      logic [15:0] addr;
      logic [15:0] data;
      logic last;
   } fps_rsp_t;

   typedef struct packed {
      logic [15:0] pulse_a;
      logic [15:0] pulse_b;
      logic [3:0] step;
      logic [15:0] ext_len;
      logic [15:0] ext_cnt;
      logic [15:0] torque;
      logic [15:0] fault_word;
   } fps_stat_t;

   typedef enum logic [1:0] {
      W_NONE = 2'h0,
      W_PARAM = 2'h1,
      W_STAT = 2'h2,
      W_FAULT = 2'h3
   } fps_win_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_FETCH = 3'b010,
      ST_HOLD = 3'b100
   } fps_state_t;

endpackage : fps_pkg

// file: fps_param_mem.sv
/*
 * Parameter word store: one write port, one read port, registered
 * read data.
 * Assumes the caller keeps addresses within the depth.
 */
`timescale 1ns/1ps

module fps_param_mem
   import fps_pkg::*;
#(
   parameter int AW = 12,
   parameter int DW = 16
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [DW-1:0] i_wdata,
   input wire logic [AW-1:0] i_raddr,
   output logic [DW-1:0] o_rdata
);

   // ************************************************************
   // storage
   // ************************************************************
   logic [DW-1:0] mem [0:(1<<AW)-1];
   logic [DW-1:0] rdata_q;

   // array left unreset so it maps onto ram
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end

   // registered read
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= mem[i_raddr];
      end
   end

   assign o_rdata = rdata_q;

endmodule : fps_param_mem

// file: fps_slave.sv
/*
 * Fieldbus parameter slave: checks decoded read and write requests,
 * answers words, echoes or exceptions, keeps the parameter store and
 * gates bus run commands and setpoint.
 * Assumes a front end that delivers one decoded frame per request
 * with its length and crc verdict, and that drains answers.
 */
`timescale 1ns/1ps
`include "fps_map.svh"

// Functional notes
// - read-only words take reads only, write-only words writes only, via 06
// - write to a read-only word is refused with code 07
// - function codes other than read and write give code 01
// - any request with good length and crc while the drive is faulty gives code 01
// - address plus count outside one permitted window gives code 02
// - structurally bad data field, here word count, gives code 03
// - invalid written value gives code 04
// - wrong password at the check address gives code 05
// - bad length or crc gives code 06
// - run-locked parameter written while running gives code 08
// - decimal values travel as integers scaled by ten to the n
// - identity word: series code high byte, model code low byte, read only
// - bus run commands and setpoint act only when channels select the bus
// - active speed step 0 to 15 is read at 3012h
// - exception answer echoes function code with top bit set plus code
// - good single write is answered by echoing the request
module fps_slave
   import fps_pkg::*;
#(
   parameter int PAW = 12,
   parameter logic [7:0] SERIES_CODE = 8'h5c, // arbitrary value
   parameter logic [7:0] MODEL_CODE = 8'h3e,  // arbitrary value
   parameter logic [15:0] MAX_WORDS = `FPS_MAX_WORDS
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_req_valid,
   input wire fps_req_t i_req,
   output logic o_req_ready,
   output logic o_rsp_valid,
   output fps_rsp_t o_rsp,
   input wire logic i_rsp_ready,
   input wire fps_stat_t i_stat,
   input wire logic i_running,
   input wire logic i_faulty,
   output logic o_run_cmd_valid,
   output logic [15:0] o_run_cmd,
   output logic [15:0] o_loop_setpoint,
   output logic o_locked
);

   // ************************************************************
   // window decode
   // ************************************************************
   // one decoder for request start, read end and fetch address
   function automatic fps_win_t win_of(input logic [16:0] a);
      if (a[16]) begin
         win_of = W_NONE;
      end else if (a[15:0] <= `FPS_PARAM_HI) begin
         win_of = W_PARAM;
      end else if (a[15:0] >= `FPS_PULSE_A && a[15:0] <= `FPS_IDENT) begin
         win_of = W_STAT;
      end else if (a[15:0] == `FPS_FAULT) begin
         win_of = W_FAULT;
      end else begin
         win_of = W_NONE;
      end
   endfunction : win_of

   // ************************************************************
   // state
   // ************************************************************
   fps_state_t st_q, st_d;
   logic [15:0] cur_q, cur_d;
   logic [15:0] left_q, left_d;
   fps_rsp_t rsp_q, rsp_d;
   logic vld_q, vld_d;
   logic [15:0] run_src_q;
   logic [15:0] run_chan_q;
   logic [15:0] loop_src_q;
   logic [15:0] pwd_q;
   logic unlock_q;
   logic run_vld_q;
   logic [15:0] run_cmd_q;
   logic [15:0] setpt_q;
   logic [15:0] mem_rdata;

   // ************************************************************
   // request decode
   // ************************************************************
   wire logic acc = i_req_valid & o_req_ready;
   wire logic is_rd = i_req.func == `FPS_FC_READ;
   wire logic is_wr = i_req.func == `FPS_FC_WRITE;
   wire logic [16:0] rd_end = {1'b0, i_req.addr} + {1'b0, i_req.data} - 17'h00001;
   wire fps_win_t w_start = win_of({1'b0, i_req.addr});
   wire fps_win_t w_end = win_of(rd_end);
   wire logic cnt_bad = (i_req.data == 16'h0000) | (i_req.data > MAX_WORDS);
   wire logic rd_range_bad = (w_start == W_NONE) | (w_start != w_end);
   wire logic wr_param = w_start == W_PARAM;
   wire logic wr_ro = (w_start == W_STAT) | (w_start == W_FAULT);
   wire logic wr_pwchk = i_req.addr == `FPS_PWD_CHECK;
   wire logic wr_cmd = i_req.addr == `FPS_CMD;
   wire logic wr_spt = i_req.addr == `FPS_SETPT;
   wire logic wr_known = wr_param | wr_pwchk | wr_cmd | wr_spt;
   wire logic run_locked = wr_param & (i_req.addr <= `FPS_RUNLOCK_HI);
   wire logic pwd_miss = wr_pwchk & (i_req.data != pwd_q);
   wire logic locked = (pwd_q != 16'h0000) & ~unlock_q;

   // value checks against each setting range
   wire logic src_bad = (i_req.addr == `FPS_RUN_SRC) & (i_req.data > `FPS_RUN_SRC_MAX);
   wire logic chan_bad = (i_req.addr == `FPS_RUN_CHAN) & (i_req.data > `FPS_CHAN_MAX);
   wire logic cmd_bad = wr_cmd & ((i_req.data < `FPS_CMD_MIN) | (i_req.data > `FPS_CMD_MAX));
   wire logic val_bad = src_bad | chan_bad | cmd_bad;

   // ************************************************************
   // exception priority
   // ************************************************************
   // first match wins, so a request never carries two codes
   // a check write passes the lock, or a
   // locked unit could never be opened
   wire logic [7:0] exc_code =
      ~i_req.frame_ok ? `FPS_EXC_FRAME :
      ~(is_rd | is_wr) ? `FPS_EXC_CMD :
      i_faulty ? `FPS_EXC_CMD :
      (locked & ~(is_wr & wr_pwchk)) ? `FPS_EXC_LOCK :
      is_rd ? (cnt_bad ? `FPS_EXC_DATA :
               rd_range_bad ? `FPS_EXC_ADDR : 8'h00) :
      wr_ro ? `FPS_EXC_RO :
      ~wr_known ? `FPS_EXC_ADDR :
      (run_locked & i_running) ? `FPS_EXC_RUN :
      val_bad ? `FPS_EXC_VALUE :
      pwd_miss ? `FPS_EXC_PWD :
      8'h00;

   wire logic exc_any = exc_code != 8'h00;
   wire logic wr_ok = acc & is_wr & ~exc_any;

   // ************************************************************
   // bus source gating
   // ************************************************************
   wire logic run_gate = (run_src_q == `FPS_RUN_SRC_BUS) & (run_chan_q == `FPS_CHAN_BUS);
   wire logic loop_gate = loop_src_q == `FPS_LOOP_SRC_BUS;

   // ************************************************************
   // parameter store
   // ************************************************************
   // words are kept exactly as sent, already scaled by ten to the n,
   // so a read returns the same integer that a write stored
   fps_param_mem #(
      .AW(PAW),
      .DW(16)
   ) u_mem (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_we(wr_ok & wr_param),
      .i_waddr(i_req.addr[PAW-1:0]),
      .i_wdata(i_req.data),
      .i_raddr(cur_q[PAW-1:0]),
      .o_rdata(mem_rdata)
   );

   // ************************************************************
   // read word select
   // ************************************************************
   wire logic [15:0] ident_word = {SERIES_CODE, MODEL_CODE};
   wire logic [15:0] step_word = {12'h000, i_stat.step};
   wire fps_win_t w_cur = win_of({1'b0, cur_q});
   wire logic [15:0] stat_word =
      (cur_q == `FPS_PULSE_A) ? i_stat.pulse_a :
      (cur_q == `FPS_PULSE_B) ? i_stat.pulse_b :
      (cur_q == `FPS_STEP) ? step_word :
      (cur_q == `FPS_EXT_LEN) ? i_stat.ext_len :
      (cur_q == `FPS_EXT_CNT) ? i_stat.ext_cnt :
      (cur_q == `FPS_TORQUE) ? i_stat.torque :
      ident_word;
   wire logic [15:0] rd_word =
      (w_cur == W_PARAM) ? mem_rdata :
      (w_cur == W_FAULT) ? i_stat.fault_word :
      stat_word;

   // ************************************************************
   // answer sequencer
   // ************************************************************
   // reads step one word at a time; the fetch state waits out the
   // registered memory read, trading speed for a plain ram
   // byte count loads once per read;
   // address, data and last per word
   always_comb begin
      st_d = st_q;
      cur_d = cur_q;
      left_d = left_q;
      rsp_d = rsp_q;
      vld_d = vld_q;
      case (st_q)
         ST_IDLE: begin
            if (acc && exc_any) begin
               rsp_d.exc = 1'b1;
               rsp_d.func = i_req.func | `FPS_EXC_FLAG;
               rsp_d.code = exc_code;
               rsp_d.addr = 16'h0000;
               rsp_d.data = 16'h0000;
               rsp_d.last = 1'b1;
               vld_d = 1'b1;
               st_d = ST_HOLD;
            end else if (acc && is_wr) begin
               rsp_d.exc = 1'b0;
               rsp_d.func = i_req.func;
               rsp_d.code = 8'h00;
               rsp_d.addr = i_req.addr;
               rsp_d.data = i_req.data;
               rsp_d.last = 1'b1;
               vld_d = 1'b1;
               st_d = ST_HOLD;
            end else if (acc) begin
               rsp_d.exc = 1'b0;
               rsp_d.func = i_req.func;
               rsp_d.code = {i_req.data[6:0], 1'b0};
               cur_d = i_req.addr;
               left_d = i_req.data;
               st_d = ST_FETCH;
            end
         end
         ST_FETCH: begin
            st_d = ST_HOLD;
         end
         ST_HOLD: begin
            if (!vld_q) begin
               rsp_d.addr = cur_q;
               rsp_d.data = rd_word;
               rsp_d.last = left_q == 16'h0001;
               vld_d = 1'b1;
            end else if (i_rsp_ready) begin
               vld_d = 1'b0;
               if (rsp_q.last) begin
                  st_d = ST_IDLE;
               end else begin
                  cur_d = cur_q + 16'h0001;
                  left_d = left_q - 16'h0001;
                  st_d = ST_FETCH;
               end
            end
         end
         default: begin
            st_d = ST_IDLE;
            vld_d = 1'b0;
         end
      endcase
   end

   // sequencer registers
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_q <= ST_IDLE;
         cur_q <= 16'h0000;
         left_q <= 16'h0000;
         rsp_q <= '0;
         vld_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cur_q <= cur_d;
         left_q <= left_d;
         rsp_q <= rsp_d;
         vld_q <= vld_d;
      end
   end

   // ************************************************************
   // control shadows and password lock
   // ************************************************************
   // shadows mirror stored words so gating needs no memory read
   // refused writes never reach them
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         run_src_q <= `FPS_CTRL_RST;
         run_chan_q <= `FPS_CTRL_RST;
         loop_src_q <= `FPS_CTRL_RST;
         pwd_q <= `FPS_CTRL_RST;
      end else if (wr_ok) begin
         if (i_req.addr == `FPS_RUN_SRC) begin
            run_src_q <= i_req.data;
         end
         if (i_req.addr == `FPS_RUN_CHAN) begin
            run_chan_q <= i_req.data;
         end
         if (i_req.addr == `FPS_LOOP_SRC) begin
            loop_src_q <= i_req.data;
         end
         if (i_req.addr == `FPS_PWD) begin
            pwd_q <= i_req.data;
         end
      end
   end

   // a new nonzero password relocks, so it must be proven before use
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         unlock_q <= 1'b0;
      end else if (wr_ok && wr_pwchk) begin
         unlock_q <= 1'b1;
      end else if (wr_ok && i_req.addr == `FPS_PWD && i_req.data != 16'h0000) begin
         unlock_q <= 1'b0;
      end
   end

   // ************************************************************
   // bus run command and setpoint
   // ************************************************************
   // commands outside the bus channel are echoed but have no effect
   // run valid is a one-cycle pulse
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         run_vld_q <= 1'b0;
         run_cmd_q <= 16'h0000;
         setpt_q <= 16'h0000;
      end else begin
         run_vld_q <= wr_ok & wr_cmd & run_gate;
         if (wr_ok && wr_cmd && run_gate) begin
            run_cmd_q <= i_req.data;
         end
         if (wr_ok && wr_spt && loop_gate) begin
            setpt_q <= i_req.data;
         end
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   // ready from state alone: next request
   // may come once the last item is taken
   assign o_req_ready = st_q == ST_IDLE;
   assign o_rsp_valid = vld_q;
   assign o_rsp = rsp_q;
   assign o_run_cmd_valid = run_vld_q;
   assign o_run_cmd = run_cmd_q;
   assign o_loop_setpoint = setpt_q;
   assign o_locked = locked;

endmodule : fps_slave

// file: fps_slave_asserts.sv
/*
 * Port checker for the fieldbus parameter slave.
 * Assumes binding onto fps_slave, one clock, async active-low reset.
 */
`timescale 1ns/1ps
`include "fps_map.svh"

module fps_slave_asserts
   import fps_pkg::*;
#(
   parameter logic [15:0] MAX_WORDS = `FPS_MAX_WORDS
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_req_valid,
   input wire fps_req_t i_req,
   input wire logic o_req_ready,
   input wire logic o_rsp_valid,
   input wire fps_rsp_t o_rsp,
   input wire logic i_rsp_ready,
   input wire fps_stat_t i_stat,
   input wire logic i_running,
   input wire logic i_faulty,
   input wire logic o_run_cmd_valid,
   input wire logic [15:0] o_run_cmd,
   input wire logic [15:0] o_loop_setpoint,
   input wire logic o_locked
);
   // ************************************************************
   // request decode
   // ************************************************************
   // taken requests, split by how far down the priority they reach
   wire logic take = i_req_valid && o_req_ready;
   wire logic good = take && i_req.frame_ok && !i_faulty;
   wire logic open_ok = good && !o_locked;
   wire logic is_rd = i_req.func == `FPS_FC_READ;
   wire logic is_wr = i_req.func == `FPS_FC_WRITE;
   wire logic ro_adr = (i_req.addr >= `FPS_PULSE_A && i_req.addr <= `FPS_IDENT)
                       || i_req.addr == `FPS_FAULT;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   // ************************************************************
   // assertions
   // ************************************************************
   // exceptions answer one cycle after the take
   property p_exc(c, logic [7:0] k);
      c |=> o_rsp_valid && o_rsp.exc && o_rsp.code == k;
   endproperty

   chk_frame_err: assert property (p_exc(take && !i_req.frame_ok, `FPS_EXC_FRAME))
      else $error("bad frame not refused");
   chk_bad_func: assert property (good && !is_rd && !is_wr |=> o_rsp.exc &&
      o_rsp.code == `FPS_EXC_CMD && o_rsp.func == ($past(i_req.func) | `FPS_EXC_FLAG))
      else $error("unknown function not refused");
   chk_fault_cmd: assert property (p_exc(take && i_req.frame_ok && i_faulty, `FPS_EXC_CMD))
      else $error("request while faulty not refused");
   chk_lock_refuse: assert property (p_exc(good && o_locked &&
      (is_rd || is_wr && i_req.addr != `FPS_PWD_CHECK), `FPS_EXC_LOCK))
      else $error("locked unit answered");
   chk_read_only: assert property (p_exc(open_ok && is_wr && ro_adr, `FPS_EXC_RO))
      else $error("read-only write not refused");
   chk_count_err: assert property (p_exc(open_ok && is_rd &&
      (i_req.data == 16'h0000 || i_req.data > MAX_WORDS), `FPS_EXC_DATA))
      else $error("bad word count not refused");
   chk_run_lock: assert property (p_exc(open_ok && is_wr && i_running &&
      i_req.addr <= `FPS_RUNLOCK_HI, `FPS_EXC_RUN))
      else $error("run-locked write not refused");
   chk_write_echo: assert property (take && is_wr ##1 o_rsp_valid && !o_rsp.exc |->
      o_rsp.addr == $past(i_req.addr) && o_rsp.data == $past(i_req.data) && o_rsp.last)
      else $error("write echo differs from request");
   chk_run_gate: assert property (o_run_cmd_valid |->
      $past(take && is_wr && i_req.addr == `FPS_CMD) && o_run_cmd == $past(i_req.data))
      else $error("run command without a bus write");
   chk_one_code: assert property (o_rsp_valid && o_rsp.exc && i_rsp_ready |=> !o_rsp_valid)
      else $error("more than one exception item");
   chk_step_range: assert property ($rose(o_rsp_valid) && !o_rsp.exc &&
      o_rsp.addr == `FPS_STEP |-> o_rsp.data == {12'h000, $past(i_stat.step)})
      else $error("speed step out of range");

   // main scenarios reached
   cov_read: cover property (take && is_rd ##2 o_rsp_valid);
   cov_run: cover property (o_run_cmd_valid);
   cov_lock: cover property (o_rsp_valid && o_rsp.code == `FPS_EXC_LOCK);
endmodule : fps_slave_asserts

// file: fps_master_model.sv
/*
 * Upper computer model: sends one request, collects every answer item.
 * Assumes one request outstanding and a slave that answers each one.
 */
`timescale 1ns/1ps

module fps_master_model
   import fps_pkg::*;
(
   input wire logic i_clk,
   output logic o_req_valid,
   output fps_req_t o_req,
   input wire logic i_req_ready,
   input wire logic i_rsp_valid,
   input wire fps_rsp_t i_rsp,
   output logic o_rsp_ready
);
   fps_rsp_t got[$];
   int stall_max = 0;

   // idle bus at start
   initial begin
      o_req_valid = 1'b0;
      o_req = '0;
      o_rsp_ready = 1'b0;
   end

   // ************************************************************
   // one transfer
   // ************************************************************
   task automatic send(input fps_req_t r);
      fps_rsp_t q;
      int n;
      got.delete();
      @(posedge i_clk);
      #1;
      o_req_valid = 1'b1;
      o_req = r;
      while (!i_req_ready) begin
         @(posedge i_clk);
         #1;
      end
      @(posedge i_clk);
      #1;
      o_req_valid = 1'b0;
      o_req = ~r; // released lines must not look valid
      // random stalls before each answer item
      do begin
         n = $urandom_range(stall_max, 0);
         if (n > 0) o_rsp_ready = 1'b0;
         repeat (n) begin
            @(posedge i_clk);
            #1;
         end
         o_rsp_ready = 1'b1;
         while (!i_rsp_valid) begin
            @(posedge i_clk);
            #1;
         end
         q = i_rsp;
         @(posedge i_clk);
         #1;
         got.push_back(q);
      end while (!q.last && got.size() < 40);
      o_rsp_ready = 1'b0;
   endtask : send
endmodule : fps_master_model

// file: fieldbus_parameter_slave_tb.sv
/*
 * Self-checking bench for the fieldbus parameter slave.
 * Assumes fps_slave, fps_master_model and the checker compiled before.
 */
`timescale 1ns/1ps

module fieldbus_parameter_slave_tb;
   import fps_pkg::*;
   localparam logic [7:0] SER = 8'h5c; // arbitrary value
   localparam logic [7:0] MDL = 8'h3e; // arbitrary value
   logic i_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_running = 1'b0;
   logic i_faulty = 1'b0;
   logic i_req_valid, i_rsp_ready, o_req_ready, o_rsp_valid, o_run_cmd_valid, o_locked;
   fps_req_t i_req;
   fps_rsp_t o_rsp;
   fps_stat_t st = '0;
   logic [15:0] o_run_cmd, o_loop_setpoint;
   logic [15:0] shadow [logic [15:0]];
   int fail_count = 0;
   int cmp_count = 0;

   // 200 MHz clock
   always #2.5 i_clk = ~i_clk;

   fps_slave #(.SERIES_CODE(SER), .MODEL_CODE(MDL)) dut (.i_clk(i_clk), .i_rst_b(i_rst_b),
      .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
      .o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp), .i_rsp_ready(i_rsp_ready), .i_stat(st),
      .i_running(i_running), .i_faulty(i_faulty), .o_run_cmd_valid(o_run_cmd_valid),
      .o_run_cmd(o_run_cmd), .o_loop_setpoint(o_loop_setpoint), .o_locked(o_locked));
   fps_master_model mst (.i_clk(i_clk), .o_req_valid(i_req_valid), .o_req(i_req),
      .i_req_ready(o_req_ready), .i_rsp_valid(o_rsp_valid), .i_rsp(o_rsp),
      .o_rsp_ready(i_rsp_ready));

   // ************************************************************
   // helpers
   // ************************************************************
   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // expected word: status inputs, identity, or what was written
   function automatic logic [15:0] exp_word(input logic [15:0] a);
      case (a)
         16'h3010: return st.pulse_a;
         16'h3011: return st.pulse_b;
         16'h3012: return {12'h000, st.step};
         16'h3013: return st.ext_len;
         16'h3014: return st.ext_cnt;
         16'h3015: return st.torque;
         16'h3016: return {SER, MDL};
         16'h5000: return st.fault_word;
         default: return shadow[a];
      endcase
   endfunction : exp_word

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      mst.send({1'b1, 8'h06, a, d});
      chk({mst.got.size(), mst.got[0]}, {32'd1, 1'b0, 8'h06, 8'h00, a, d, 1'b1});
      shadow[a] = d;
   endtask : wr

   task automatic rd(input logic [15:0] a, input int n);
      mst.send({1'b1, 8'h03, a, 16'(n)});
      chk(mst.got.size(), n);
      foreach (mst.got[k])
         chk(mst.got[k], {1'b0, 8'h03, 8'(2 * n), a + 16'(k), exp_word(a + 16'(k)),
            k == n - 1});
   endtask : rd

   task automatic ex(input logic fo, input logic [7:0] f, input logic [15:0] a, d,
      input logic [7:0] k);
      mst.send({fo, f, a, d});
      chk({mst.got.size(), mst.got[0]}, {32'd1, 1'b1, f | 8'h80, k, 33'h000000001});
   endtask : ex

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test

   // ************************************************************
   // tests
   // ************************************************************
   // watchdog: whole run is a few hundred cycles
   initial begin
      #100000;
      fail_count++;
      finish_test();
   end

   // main sequence
   initial begin
      void'($urandom(32'h8bcf7040));
      repeat (6) @(posedge i_clk);
      #1 i_rst_b = 1'b1;
      chk({o_req_ready, o_rsp_valid, o_locked, o_run_cmd, o_loop_setpoint}, 35'h400000000);
      mst.stall_max = 3;
      wr(16'h0114, 16'h0032);
      rd(16'h0114, 1);
      for (int k = 0; k < 16; k++) wr(16'h0200 + 16'(k), 16'($urandom));
      rd(16'h0200, 16);
      $display("test words done");
      for (int k = 0; k < 2; k++) begin
         st = fps_stat_t'({$urandom, $urandom, $urandom, $urandom});
         if (k == 1) st.step = 4'hf;
         rd(16'h3010, 7);
         rd(16'h5000, 1);
      end
      $display("test status done");
      ex(1'b0, 8'h06, 16'h0114, 16'h0001, 8'h06);
      ex(1'b1, 8'h10, 16'h0000, 16'h0001, 8'h01);
      ex(1'b1, 8'h06, 16'h3012, 16'h0005, 8'h07);
      ex(1'b1, 8'h06, 16'h5000, 16'h0005, 8'h07);
      ex(1'b1, 8'h03, 16'h0200, 16'h0000, 8'h03);
      ex(1'b1, 8'h03, 16'h0200, 16'h0011, 8'h03);
      ex(1'b1, 8'h03, 16'h0ffe, 16'h0004, 8'h02);
      ex(1'b1, 8'h03, 16'h2000, 16'h0001, 8'h02);
      ex(1'b1, 8'h06, 16'h2000, 16'h0009, 8'h04);
      ex(1'b1, 8'h06, 16'h0001, 16'h0003, 8'h04);
      ex(1'b1, 8'h06, 16'h1f00, 16'h0005, 8'h05);
      i_running = 1'b1;
      ex(1'b1, 8'h06, 16'h0003, 16'h0001, 8'h08);
      i_running = 1'b0;
      i_faulty = 1'b1;
      ex(1'b1, 8'h03, 16'h0200, 16'h0001, 8'h01);
      i_faulty = 1'b0;
      $display("test exceptions done");
      wr(16'h2000, 16'h0001);
      wr(16'h2002, 16'h1234);
      chk({o_run_cmd, o_loop_setpoint}, 32'h0);
      wr(16'h0001, 16'h0002);
      wr(16'h0900, 16'h0007);
      wr(16'h2000, 16'h0005);
      wr(16'h2002, 16'h1234);
      chk({o_run_cmd, o_loop_setpoint}, 32'h00051234);
      $display("test gating done");
      wr(16'h0700, 16'h1111);
      chk(o_locked, 1);
      ex(1'b1, 8'h03, 16'h0200, 16'h0001, 8'h09);
      ex(1'b1, 8'h06, 16'h0200, 16'h0001, 8'h09);
      ex(1'b1, 8'h06, 16'h1f00, 16'h2222, 8'h05);
      wr(16'h1f00, 16'h1111);
      chk(o_locked, 0);
      $display("test lock done");
      finish_test();
   end
endmodule : fieldbus_parameter_slave_tb

bind fps_slave fps_slave_asserts #(.MAX_WORDS(MAX_WORDS)) u_chk (.i_clk(i_clk),
   .i_rst_b(i_rst_b), .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
   .o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp), .i_rsp_ready(i_rsp_ready), .i_stat(i_stat),
   .i_running(i_running), .i_faulty(i_faulty), .o_run_cmd_valid(o_run_cmd_valid),
   .o_run_cmd(o_run_cmd), .o_loop_setpoint(o_loop_setpoint), .o_locked(o_locked));
